// >>> pkg/cbp_map.svh
// Constants for the address, data and parity bus: field positions, reset values and timing counts.
`ifndef CBP_MAP_SVH
`define CBP_MAP_SVH
`define CBP_DATA_W 32
`define CBP_LANES 4
`define CBP_ADDR_W 30
`define CBP_INV_LSB 2
`define CBP_BE_IDLE 4'hF
`define CBP_PARITY_CHECK_STATUS_N_IDLE 1'h1
`define CBP_FIFO_DEPTH 16
`define CBP_READ_WAIT 2
`endif

// >>> pkg/cbp_pkg.sv
// Types shared by both ends of the address, data and parity bus.
package cbp_pkg;
    typedef enum logic [1:0] {
        CBP_IDLE = 2'b00,
        CBP_ADDR = 2'b01,
        CBP_DATA = 2'b10
    } cbp_state_type;
    typedef enum logic [1:0] {
        CBP_SIZE_32 = 2'b00,
        CBP_SIZE_16 = 2'b01,
        CBP_SIZE_8 = 2'b10
    } cbp_size_type;
endpackage

// >>> pkg/cbp_bus_if.sv
// Interface joining the processor end and the system end of the bus.
`timescale 1ns/1ns
interface cbp_bus_if;
    logic [29:0] addr_out;
    logic addr_oe;
    logic [29:0] inv_addr_out;
    logic inv_addr_oe;
    logic [3:0] byte_lane_enable_n;
    logic be_oe;
    logic cycle_start;
    logic cycle_write;
    logic cycle_fill;
    logic ready;
    logic [1:0] bus_size;
    logic bus_hold;
    logic addr_hold;
    logic [31:0] cpu_data_out;
    logic [3:0] cpu_parity_out;
    logic cpu_data_oe;
    logic [31:0] sys_data_out;
    logic [3:0] sys_parity_out;
    logic sys_data_oe;
    logic parity_check_status_n;
    // Resolved levels of the shared lines; undriven lines read as pulled high.
    wire [29:0] word_address_lines = addr_oe ? addr_out : (inv_addr_oe ? inv_addr_out : '1);
    wire [31:0] data_lines = cpu_data_oe ? cpu_data_out : (sys_data_oe ? sys_data_out : '1);
    wire [3:0] byte_parity_lines = cpu_data_oe ? cpu_parity_out : (sys_data_oe ? sys_parity_out : 4'hF);
    modport cpu (
        output addr_out, addr_oe, byte_lane_enable_n, be_oe, cycle_start, cycle_write, cycle_fill,
        output cpu_data_out, cpu_parity_out, cpu_data_oe, parity_check_status_n,
        input ready, bus_size, bus_hold, addr_hold, word_address_lines, data_lines, byte_parity_lines
    );
    modport sys (
        output inv_addr_out, inv_addr_oe, ready, bus_size, bus_hold, addr_hold,
        output sys_data_out, sys_parity_out, sys_data_oe,
        input addr_out, addr_oe, byte_lane_enable_n, be_oe, cycle_start, cycle_write, cycle_fill,
        input cpu_parity_out, cpu_data_oe, parity_check_status_n, word_address_lines, data_lines, byte_parity_lines
    );
endinterface

// >>> core/cbp_fifo.sv
// Parameterised first-in first-out buffer with valid and ready on both sides.
`timescale 1ns/1ns
module cbp_fifo
    import cbp_pkg::*;
#(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
)
(
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    logic push;
    logic pop;

    // Full and empty come straight from the occupancy count.
    assign in_ready_out = (count_r != (AW+1)'(DEPTH));
    assign out_valid_out = (count_r != '0);
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    assign out_data_out = mem_r[rd_ptr_r];

    // Storage is written without reset; only the pointers and the count carry state.
    always_ff @(posedge ref_clk_in)
    begin
        if (push)
        begin
            mem_r[wr_ptr_r] <= in_data_in;
        end
    end

    // Pointers wrap at the depth, which need not be a power of two.
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + AW'(1);
            end
            if (pop)
            begin
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + AW'(1);
            end
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// >>> core/cbp_cpu_end.sv
// Processor end: address, byte enables, write data with parity and read parity checking.
`timescale 1ns/1ns
`include "cbp_map.svh"
// Notes on behaviour
// - All timing on rising edge of clock.
// - Drive word address with byte enables.
// - System may drive invalidation address bits.
// - Release address during bus or address hold.
// - System returns all bytes on fill.
// - Each enable qualifies one data byte.
// - Byte enables active low, released in bus hold.
// - Data active high, bit zero least significant.
// - Write data driven from second clock.
// - One parity bit per byte, same timing.
// - Generate write parity with write data.
// - System returns even read parity.
// - Read parity never alters delivered data.
// - Status driven the clock after ready.
// - Parity error shown by status low.
// - Only enabled bytes are checked; with no byte enabled and an 8-bit bus size, lane 3 is checked.
// - Status high otherwise, always driven.
module cbp_cpu_end
    import cbp_pkg::*;
#(
    parameter int FIFO_DEPTH = `CBP_FIFO_DEPTH
)
(
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    cbp_bus_if.cpu bus,
    input wire logic req_valid_in,
    output logic req_ready_out,
    input wire logic req_write_in,
    input wire logic req_fill_in,
    input wire logic [29:0] req_addr_in,
    input wire logic [3:0] req_be_n_in,
    input wire logic [31:0] req_wdata_in,
    output logic rd_valid_out,
    output logic [31:0] rd_data_out,
    output logic parity_error_out,
    output logic inval_valid_out,
    output logic [27:0] inval_addr_out
);
    localparam int REQ_W = 1 + 1 + 30 + 4 + 32;
    cbp_state_type state_r;
    logic [REQ_W-1:0] cur_r;
    logic [REQ_W-1:0] fifo_data;
    logic fifo_valid;
    logic fifo_pop;
    logic check_r;
    logic [31:0] samp_data_r;
    logic status_n_r;
    logic hold_d_r;

    // Even parity per byte: the parity bit makes the byte plus bit hold an even count of ones.
    function automatic logic [3:0] even_parity(input logic [31:0] d);
        logic [3:0] p;
        p = '0;
        for (int i = 0; i < `CBP_LANES; i++)
        begin
            p[i] = ^d[8*i +: 8];
        end
        return p;
    endfunction

    // Lanes that take part in the check: the enables, narrowed by the returned bus size.
    function automatic logic [3:0] checked_lanes(input logic [3:0] be_n, input logic [1:0] size);
        logic [3:0] en;
        en = ~be_n;
        if (size == CBP_SIZE_8)
        begin
            en = (en[0]) ? 4'h1 : (en[1]) ? 4'h2 : (en[2]) ? 4'h4 : 4'h8;
        end
        else if (size == CBP_SIZE_16)
        begin
            en = (|en[1:0]) ? (en & 4'h3) : (en & 4'hC);
        end
        return en;
    endfunction

    // Requests queue in front of the bus so the user side can keep issuing while a cycle runs, until FIFO_DEPTH entries wait.
    cbp_fifo #(
        .WIDTH(REQ_W),
        .DEPTH(FIFO_DEPTH)
    ) u_req_fifo (
        .ref_clk_in(ref_clk_in),
        .resetn_in(resetn_in),
        .in_valid_in(req_valid_in),
        .in_ready_out(req_ready_out),
        .in_data_in({req_write_in, req_fill_in, req_addr_in, req_be_n_in, req_wdata_in}),
        .out_valid_out(fifo_valid),
        .out_ready_in(fifo_pop),
        .out_data_out(fifo_data)
    );

    // A new cycle starts only when idle and no hold is asserted.
    assign fifo_pop = (state_r == CBP_IDLE) && fifo_valid && !bus.bus_hold && !bus.addr_hold;

    // Bus cycle sequencer: first clock carries address only, data follows from the second.
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            state_r <= CBP_IDLE;
            cur_r <= '0;
        end
        else
        begin
            unique case (state_r)
                CBP_IDLE:
                begin
                    if (fifo_pop)
                    begin
                        cur_r <= fifo_data;
                        state_r <= CBP_ADDR;
                    end
                end
                CBP_ADDR:
                begin
                    state_r <= CBP_DATA;
                end
                CBP_DATA:
                begin
                    if (bus.ready)
                    begin
                        state_r <= CBP_IDLE;
                    end
                end
                default:
                begin
                    state_r <= CBP_IDLE;
                end
            endcase
        end
    end

    wire cur_write = cur_r[REQ_W-1];
    wire in_cycle = (state_r != CBP_IDLE);

    // Address stays off the lines whenever a hold is in force; enables stay off only during bus hold.
    assign bus.addr_out = cur_r[65:36];
    assign bus.addr_oe = in_cycle && !bus.bus_hold && !bus.addr_hold;
    assign bus.byte_lane_enable_n = in_cycle ? cur_r[35:32] : `CBP_BE_IDLE;
    assign bus.be_oe = in_cycle && !bus.bus_hold;
    assign bus.cycle_start = (state_r == CBP_ADDR);
    assign bus.cycle_write = cur_write;
    assign bus.cycle_fill = cur_r[REQ_W-2];

    // Write data and its parity share one enable, never in the first clock.
    assign bus.cpu_data_out = cur_r[31:0];
    assign bus.cpu_parity_out = even_parity(cur_r[31:0]);
    assign bus.cpu_data_oe = (state_r == CBP_DATA) && cur_write && !bus.bus_hold;

    // Sample read data at every edge and register the read ready; data and flag appear one clock later.
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            check_r <= 1'b0;
            samp_data_r <= '0;
        end
        else
        begin
            check_r <= (state_r == CBP_DATA) && bus.ready && !cur_write;
            samp_data_r <= bus.data_lines;
        end
    end

    // Status is registered so it can be low only in the clock after a read's ready, and is high otherwise.
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            status_n_r <= `CBP_PARITY_CHECK_STATUS_N_IDLE;
        end
        else if ((state_r == CBP_DATA) && bus.ready && !cur_write)
        begin
            status_n_r <= ~|(checked_lanes(cur_r[35:32], bus.bus_size)
                & (even_parity(bus.data_lines) ^ bus.byte_parity_lines));
        end
        else
        begin
            status_n_r <= `CBP_PARITY_CHECK_STATUS_N_IDLE;
        end
    end
    assign bus.parity_check_status_n = status_n_r;

    // Read data goes to the user untouched; parity only feeds the error flag.
    assign rd_valid_out = check_r;
    assign rd_data_out = samp_data_r;
    assign parity_error_out = ~status_n_r;

    // Invalidation address is taken from bits 31..4 every clock and flagged valid once, at the edge where address hold is first seen.
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            hold_d_r <= 1'b0;
            inval_valid_out <= 1'b0;
            inval_addr_out <= '0;
        end
        else
        begin
            hold_d_r <= bus.addr_hold;
            inval_valid_out <= bus.addr_hold && !hold_d_r;
            inval_addr_out <= bus.word_address_lines[29:`CBP_INV_LSB];
        end
    end
endmodule

// >>> core/cbp_sys_end.sv
// System end: answers cycles with read data and even parity, accepts writes, drives invalidations.
`timescale 1ns/1ns
`include "cbp_map.svh"
module cbp_sys_end
    import cbp_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    cbp_bus_if.sys bus,
    input wire logic [31:0] rd_data_in,
    input wire logic [1:0] bus_size_in,
    input wire logic bus_hold_in,
    input wire logic addr_hold_in,
    input wire logic [27:0] inval_addr_in,
    output logic wr_valid_out,
    output logic [29:0] wr_addr_out,
    output logic [31:0] wr_data_out,
    output logic [3:0] wr_be_n_out,
    output logic wr_parity_error_out,
    output logic parity_fail_seen_out
);
    logic [1:0] wait_r;
    logic busy_r;

    // Ready follows a fixed wait after the cycle start.
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            busy_r <= 1'b0;
            wait_r <= '0;
        end
        else if (bus.cycle_start)
        begin
            busy_r <= 1'b1;
            wait_r <= 2'(`CBP_READ_WAIT - 1);
        end
        else if (busy_r && wait_r != 2'h0)
        begin
            wait_r <= wait_r - 2'h1;
        end
        else if (busy_r)
        begin
            busy_r <= 1'b0;
        end
    end

    assign bus.ready = busy_r && (wait_r == 2'h0);
    assign bus.bus_size = bus_size_in;
    assign bus.bus_hold = bus_hold_in;
    assign bus.addr_hold = addr_hold_in;

    // Reads return all four lanes whatever the enables show, covering fill cycles too.
    assign bus.sys_data_out = rd_data_in;
    assign bus.sys_parity_out = {^rd_data_in[31:24], ^rd_data_in[23:16], ^rd_data_in[15:8], ^rd_data_in[7:0]};
    assign bus.sys_data_oe = busy_r && !bus.cycle_write;

    // Bits 31..4 carry the invalidation address; bits 3 and 2 are driven high by the system.
    assign bus.inv_addr_out = {inval_addr_in, 2'h3};
    assign bus.inv_addr_oe = addr_hold_in;

    // Write capture at ready, with an even-parity check on the enabled lanes.
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            wr_valid_out <= 1'b0;
            wr_addr_out <= '0;
            wr_data_out <= '0;
            wr_be_n_out <= `CBP_BE_IDLE;
            wr_parity_error_out <= 1'b0;
            parity_fail_seen_out <= 1'b0;
        end
        else
        begin
            wr_valid_out <= bus.ready && bus.cycle_write;
            wr_addr_out <= bus.addr_out;
            wr_data_out <= bus.data_lines;
            wr_be_n_out <= bus.byte_lane_enable_n;
            wr_parity_error_out <= bus.ready && bus.cycle_write && |(~bus.byte_lane_enable_n
                & ({^bus.data_lines[31:24], ^bus.data_lines[23:16], ^bus.data_lines[15:8],
                ^bus.data_lines[7:0]} ^ bus.byte_parity_lines));
            parity_fail_seen_out <= !bus.parity_check_status_n;
        end
    end
endmodule

// >>> bench/cbp_assertions.sv
// Checker for the address, data and parity bus as seen on the joining interface.
`timescale 1ns/1ns
module cbp_assertions (
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire logic [29:0] addr_out,
    input wire logic addr_oe,
    input wire logic [3:0] byte_lane_enable_n,
    input wire logic be_oe,
    input wire logic bus_hold,
    input wire logic addr_hold,
    input wire logic cycle_start,
    input wire logic cycle_write,
    input wire logic ready,
    input wire logic [31:0] cpu_data_out,
    input wire logic [3:0] cpu_parity_out,
    input wire logic cpu_data_oe,
    input wire logic [31:0] data_lines,
    input wire logic [3:0] byte_parity_lines,
    input wire logic parity_check_status_n
);
    // Even parity: each bit is the XOR of its byte, so byte plus bit hold an even count of ones.
    function automatic logic [3:0] par(input logic [31:0] d);
        par = {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]};
    endfunction
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!resetn_in);
    // Status may only drop in the clock after a read was readied, and only for one clock.
    AST_STATUS_CAUSE: assert property (!parity_check_status_n |-> $past(ready) && !$past(cycle_write))
        else $error("status low without a read ready");
    AST_STATUS_ONE: assert property (!parity_check_status_n |=> parity_check_status_n)
        else $error("status low for more than one clock");
    AST_GOOD_READ: assert property (ready && !cycle_write && byte_parity_lines == par(data_lines)
        |=> parity_check_status_n)
        else $error("error flagged on good parity");
    // Address lines are released while either hold has lasted a full clock, enables while bus hold has.
    AST_ADDR_HOLD: assert property ((bus_hold || addr_hold) && $past(bus_hold || addr_hold) |-> !addr_oe)
        else $error("address driven during hold");
    AST_BE_HOLD: assert property (bus_hold && $past(bus_hold) |-> !be_oe)
        else $error("byte enables driven during bus hold");
    AST_WR_DATA: assert property (cycle_start && cycle_write |-> !cpu_data_oe ##1 cpu_data_oe)
        else $error("write data not from the second clock");
    AST_WR_PAR: assert property (cpu_data_oe |-> cpu_parity_out == par(cpu_data_out))
        else $error("write parity not even");
    AST_READY_TIME: assert property (cycle_start |-> ##2 ready)
        else $error("ready not two clocks after start");
    AST_ADDR_STAND: assert property (cycle_start |-> addr_oe && be_oe
        ##1 $stable(addr_out) && $stable(byte_lane_enable_n))
        else $error("address or enables not held");
    COV_WRITE: cover property (cycle_start && cycle_write);
    COV_READ: cover property (ready && !cycle_write);
    COV_HOLD: cover property (bus_hold ##1 !bus_hold);
endmodule

// >>> bench/tb_top.sv
// Self-checking bench for both ends of the address, data and parity bus.
`timescale 1ns/1ns
module tb_top;
    import cbp_pkg::*;
    logic ref_clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic req_valid = 1'b0, req_valid2 = 1'b0, req_write = 1'b0, req_fill = 1'b0;
    logic [29:0] req_addr = 30'h0, a;
    logic [3:0] req_be_n = 4'hF;
    logic [31:0] req_wdata = 32'h0, rd_data_in = 32'h0, d;
    logic [1:0] bus_size = 2'h0;
    logic bus_hold = 1'b0, addr_hold = 1'b0;
    logic [27:0] inval_addr = 28'h0, inval_out;
    logic req_ready, req_ready2, rd_valid, rd_valid2, perr, perr2, inval_valid, wr_valid, wr_perr;
    logic [31:0] rd_data, rd_data2, wr_data;
    logic [29:0] wr_addr;
    logic [3:0] wr_be_n;
    logic pfs;
    logic [3:0] be_tab [4] = '{4'h0, 4'hE, 4'h5, 4'h7};
    logic [3:0] flip_f [6] = '{4'h0, 4'h1, 4'h8, 4'h4, 4'h2, 4'h2};
    logic [3:0] be_f [6] = '{4'h0, 4'h0, 4'hE, 4'h0, 4'h0, 4'h0};
    logic [1:0] sz_f [6] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h1};
    logic err_f [6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
    int miscompares = 0, n_tests = 0, n;
    cbp_bus_if bus_i ();
    cbp_bus_if bus_f ();
    // The second processor end faces the bench, which plays a system that may return bad parity.
    cbp_cpu_end i_cbp_cpu_end (.ref_clk_in, .resetn_in, .bus(bus_i), .req_valid_in(req_valid),
        .req_ready_out(req_ready), .req_write_in(req_write), .req_fill_in(req_fill), .req_addr_in(req_addr),
        .req_be_n_in(req_be_n), .req_wdata_in(req_wdata), .rd_valid_out(rd_valid), .rd_data_out(rd_data),
        .parity_error_out(perr), .inval_valid_out(inval_valid), .inval_addr_out(inval_out));
    cbp_sys_end i_cbp_sys_end (.ref_clk_in, .resetn_in, .bus(bus_i), .rd_data_in, .bus_size_in(bus_size),
        .bus_hold_in(bus_hold), .addr_hold_in(addr_hold), .inval_addr_in(inval_addr), .wr_valid_out(wr_valid),
        .wr_addr_out(wr_addr), .wr_data_out(wr_data), .wr_be_n_out(wr_be_n), .wr_parity_error_out(wr_perr),
        .parity_fail_seen_out(pfs));
    cbp_cpu_end i_cbp_cpu_end_f (.ref_clk_in, .resetn_in, .bus(bus_f), .req_valid_in(req_valid2),
        .req_ready_out(req_ready2), .req_write_in(req_write), .req_fill_in(req_fill), .req_addr_in(req_addr),
        .req_be_n_in(req_be_n), .req_wdata_in(req_wdata), .rd_valid_out(rd_valid2), .rd_data_out(rd_data2),
        .parity_error_out(perr2), .inval_valid_out(), .inval_addr_out());
    cbp_assertions i_cbp_assertions (.ref_clk_in, .resetn_in, .addr_out(bus_i.addr_out), .addr_oe(bus_i.addr_oe),
        .byte_lane_enable_n(bus_i.byte_lane_enable_n), .be_oe(bus_i.be_oe), .bus_hold(bus_i.bus_hold),
        .addr_hold(bus_i.addr_hold), .cycle_start(bus_i.cycle_start), .cycle_write(bus_i.cycle_write),
        .ready(bus_i.ready), .cpu_data_out(bus_i.cpu_data_out), .cpu_parity_out(bus_i.cpu_parity_out),
        .cpu_data_oe(bus_i.cpu_data_oe), .data_lines(bus_i.data_lines), .byte_parity_lines(bus_i.byte_parity_lines),
        .parity_check_status_n(bus_i.parity_check_status_n));
    // Free-running 125 MHz clock.
    initial forever #4 ref_clk_in = ~ref_clk_in;
    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Waits at falling edges, where outputs have settled, for one of the completion pulses or the cycle start on bus_f.
    task automatic wait_for(input int which);
        logic [4:0] f;
        for (int i = 0; i < 300; i++)
        begin
            @(negedge ref_clk_in);
            f = {rd_valid2, bus_f.cycle_start, inval_valid, rd_valid, wr_valid};
            if (f[which] === 1'b1)
                return;
        end
        miscompares++;
        end_of_test();
    endtask
    // Holds the request until an edge that sees the buffer ready, so the entry is taken there.
    task automatic push(input logic sel, w, fill, input logic [29:0] ad, input logic [3:0] be, input logic [31:0] wd);
        logic taken;
        taken = 1'b0;
        @(posedge ref_clk_in);
        req_write <= w;
        req_fill <= fill;
        req_addr <= ad;
        req_be_n <= be;
        req_wdata <= wd;
        req_valid <= !sel;
        req_valid2 <= sel;
        for (int i = 0; i < 50; i++)
        begin
            @(posedge ref_clk_in);
            if ((sel ? req_ready2 : req_ready) === 1'b1)
            begin
                taken = 1'b1;
                break;
            end
        end
        req_valid <= 1'b0;
        req_valid2 <= 1'b0;
        // A request that is never taken is a hang, so it ends the run as a failure.
        if (!taken)
        begin
            miscompares++;
            end_of_test();
        end
    endtask
    // Main sequence.
    initial
    begin
        bus_f.ready = 1'b0;
        bus_f.sys_data_oe = 1'b0;
        bus_f.sys_data_out = 32'h0;
        bus_f.sys_parity_out = 4'h0;
        bus_f.bus_size = 2'h0;
        bus_f.bus_hold = 1'b0;
        bus_f.addr_hold = 1'b0;
        bus_f.inv_addr_oe = 1'b0;
        bus_f.inv_addr_out = 30'h0;
        repeat (2) @(posedge ref_clk_in);
        resetn_in <= 1'b1;
        @(negedge ref_clk_in);
        check("idle status", bus_i.parity_check_status_n, 1'b1);
        // Write then read back at each lane pattern; the second read is a line fill with one lane enabled.
        for (int k = 0; k < 4; k++)
        begin
            a = {28'h0000100, k[1:0]};
            d = {28'h1234567, k[3:0]};
            push(1'b0, 1'b1, 1'b0, a, be_tab[k], d);
            wait_for(0);
            check("wr_addr", 32'(wr_addr), 32'(a));
            check("wr_data", wr_data, d);
            check("wr_be_n", 32'(wr_be_n), 32'(be_tab[k]));
            check("wr_perr", 32'(wr_perr), 32'h0);
            @(posedge ref_clk_in);
            rd_data_in <= ~d;
            push(1'b0, 1'b0, k == 1, a, (k == 1) ? be_tab[k] : 4'h0, 32'h0);
            wait_for(1);
            check("rd_data", rd_data, ~d);
            check("perr", 32'(perr), 32'h0);
        end
        check("fail_seen", 32'(pfs), 32'h0);
        $display("test write read done");
        // Bus hold stops cycles, so the buffer fills until it refuses, then drains in order.
        @(posedge ref_clk_in);
        bus_hold <= 1'b1;
        req_write <= 1'b1;
        req_fill <= 1'b0;
        req_be_n <= 4'h0;
        req_wdata <= 32'h0;
        repeat (3) @(posedge ref_clk_in);
        req_valid <= 1'b1;
        n = 0;
        repeat (24)
        begin
            @(posedge ref_clk_in);
            if (req_ready === 1'b1)
                n++;
            req_wdata <= 32'(n);
        end
        req_valid <= 1'b0;
        check("accepted", n, 16);
        check("be_oe in hold", 32'(bus_i.be_oe), 32'h0);
        bus_hold <= 1'b0;
        for (int i = 0; i < 16; i++)
        begin
            wait_for(0);
            check("drained", wr_data, i);
        end
        $display("test buffer done");
        // The system drives an invalidation address while it holds the address lines.
        @(posedge ref_clk_in);
        inval_addr <= 28'hABCDEF1;
        addr_hold <= 1'b1;
        wait_for(2);
        check("inval_addr", 32'(inval_out), 32'h0ABCDEF1);
        @(posedge ref_clk_in);
        addr_hold <= 1'b0;
        $display("test invalidation done");
        // Every byte of the pattern holds four ones, so correct parity is all zero and flips inject errors.
        for (int k = 0; k < 6; k++)
        begin
            push(1'b1, 1'b0, 1'b0, 30'h0000040, be_f[k], 32'h0);
            wait_for(3);
            @(posedge ref_clk_in);
            @(posedge ref_clk_in);
            bus_f.bus_size <= sz_f[k];
            bus_f.sys_data_oe <= 1'b1;
            bus_f.sys_data_out <= 32'hA5C30F71;
            bus_f.sys_parity_out <= flip_f[k];
            bus_f.ready <= 1'b1;
            @(posedge ref_clk_in);
            bus_f.ready <= 1'b0;
            bus_f.sys_data_oe <= 1'b0;
            @(negedge ref_clk_in);
            check("status", 32'(bus_f.parity_check_status_n), 32'(!err_f[k]));
            check("perr2", 32'(perr2), 32'(err_f[k]));
            check("rd_valid2", 32'(rd_valid2), 32'h1);
            check("rd_data2", rd_data2, 32'hA5C30F71);
        end
        $display("test read parity done");
        end_of_test();
    end
endmodule
